// *** design/lan_csr_pkg.sv ***
// Purpose: Shared constants and state types for the register access block.
// Assumes: One 100 MHz clock, synchronous active-high reset.
// Notes: Bit positions follow the primary control and status layout.
package lan_csr_pkg;
  // Clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;
  // Heartbeat window after a transmission, in nanoseconds (4.0 us).
  localparam int HB_WINDOW_NS = 4000;
  // Longest wait rounds down to whole cycles.
  localparam int HB_WINDOW_CYC = HB_WINDOW_NS / CLK_PERIOD_NS;
  // Byte count at which the overlength flag is raised.
  localparam logic [10:0] OVERLENGTH_TRANSMIT_FLAG_LIMIT = 11'h5ef;
  // Register indices selected by the pointer.
  localparam logic [1:0] IDX_PRIMARY_CONTROL_STATUS = 2'h0;
  // Primary register field positions.
  localparam int B_ERR = 15;
  localparam int B_OVERLENGTH_TRANSMIT_FLAG = 14;
  localparam int B_HEARTBEAT_MISSING_FLAG = 13;
  localparam int B_MISS = 12;
  localparam int B_BUS_TIMEOUT_FLAG = 11;
  localparam int B_INTERRUPT_FLAG = 7;
  localparam int B_INTERRUPT_ENABLE_BIT = 6;
  localparam int B_STOP = 2;
  localparam int B_STRT = 1;
  localparam int B_INIT = 0;
  // Reset value of the primary register: halted.
  localparam logic [15:0] PRIMARY_CONTROL_STATUS_RESET = 16'h0004;
  // Quadword alignment mask for descriptor entries (byte address).
  localparam logic [23:0] QUAD_MASK = 24'h000007;
  // Heartbeat monitor states.
  typedef enum logic [1:0] {
    HB_IDLE = 2'b00,
    HB_TX = 2'b01,
    HB_WAIT = 2'b10
  } hb_state_t;
  // Heartbeat monitor state.
  typedef struct packed {
    hb_state_t st;
    logic [9:0] cnt;
    logic seen;
    logic miss;
  } hb_t;
  // Register block state.
  typedef struct packed {
    logic [1:0] ptr;
    logic [2:0][15:0] cfg;
    logic stop;
    logic interrupt_enable_bit;
    logic overlength_transmit_flag;
    logic heartbeat_missing_flag;
    logic miss;
    logic bus_timeout_flag;
    logic [10:0] tx_cnt;
    logic busy;
    logic ready_n;
    logic [15:0] dout;
    logic oe;
    logic interrupt_flag_n;
    logic misal;
  } csr_t;
endpackage : lan_csr_pkg

// *** design/heartbeat_monitor.sv ***
// Purpose: Detects a missing collision heartbeat around each transmission that starts while no trailing window is open.
// Assumes: Inputs synchronous to CLOCK.
// Notes: Emits a one-cycle pulse when the window closes without collision.
`timescale 1ns/1ps
module heartbeat_monitor #(
  parameter int WINDOW_CYC = lan_csr_pkg::HB_WINDOW_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Monitor inputs.
  input wire logic enable,
  input wire logic tx_active,
  input wire logic collision,
  // Missing heartbeat pulse.
  output logic missing
);
  // Current and next state.
  lan_csr_pkg::hb_t q, d;

  // Next-state logic: watch the transmission, then the trailing window.
  always_comb begin
    d = q;
    d.miss = 1'b0;
    case (q.st)
      lan_csr_pkg::HB_IDLE: begin
        // A new frame starts with a heartbeat seen only if collision is present in its first cycle.
        if (enable && tx_active) begin
          d.st = lan_csr_pkg::HB_TX;
          d.seen = collision;
        end
      end
      lan_csr_pkg::HB_TX: begin
        // Collision during the frame counts as heartbeat.
        if (collision) begin
          d.seen = 1'b1;
        end
        if (!tx_active) begin
          d.st = lan_csr_pkg::HB_WAIT;
          d.cnt = 10'h000;
        end
      end
      lan_csr_pkg::HB_WAIT: begin
        // Collision within the window after the frame also counts.
        d.cnt = q.cnt + 10'h001;
        if (collision) begin
          d.seen = 1'b1;
        end
        if (q.cnt == 10'(WINDOW_CYC - 1)) begin
          d.st = lan_csr_pkg::HB_IDLE;
          d.miss = !(q.seen || collision);
        end
      end
      default: begin
        d.st = lan_csr_pkg::HB_IDLE;
      end
    endcase
    // Halting abandons any frame in progress.
    if (!enable) begin
      d.st = lan_csr_pkg::HB_IDLE;
      d.miss = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Pulse output comes from a flip-flop.
  assign missing = q.miss;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // The pulse only comes at the close of the trailing window.
  property p_hb_close;
    q.miss |-> $past(q.st) == lan_csr_pkg::HB_WAIT && !$past(q.seen);
  endproperty
  a_hb_close: assert property (p_hb_close) else $error("heartbeat pulse out of window");
endmodule : heartbeat_monitor

// *** design/lan_csr_access.sv ***
// Purpose: Indirect pointer/data register access and network error flags.
// Assumes: Slave cycle pins synchronous to CLOCK; host keeps them stable.
// Notes: Undefined reads of locked registers return zero.
// What this block does
// - Four registers, reached only through two ports.
// - Pointer holds until rewritten by host.
// - Select low is data, high is pointer.
// - Locked registers need the halt bit set.
// - Locked access still ready; reads undefined, writes dropped.
// - Pointer low two bits select; upper read zero.
// - Reset clears pointer to register zero.
// - Overlength flag set after 1519 sent bytes.
// - Overlength flag interrupts when enabled.
// - Error flags: write-one clear, halt clears.
// - Missing heartbeat within 4.0 us sets flag.
// - Heartbeat flag never interrupts.
// - Frame dropped without buffer sets lost flag.
// - Overflow without buffer not reported separately.
// - Lost-frame flag interrupts when enabled.
// - Init block word aligned, twelve words.
// - Descriptors quadword aligned, buffers any byte.
// - Interrupt pin low when enabled and flagged.
// - Error summary is OR of four flags.
`timescale 1ns/1ps
module lan_csr_access (
  // Clock and reset.
  input wire logic CLOCK,
  input wire logic RST,
  // Host slave cycle.
  input wire logic CS_N,
  input wire logic READ,
  input wire logic DAS_N,
  input wire logic ADR,
  input wire logic [15:0] DAL_IN,
  output logic [15:0] DAL_OUT,
  output logic DAL_OE,
  output logic READY_N,
  // Network events.
  input wire logic TX_ACTIVE,
  input wire logic TX_BYTE,
  input wire logic COLLISION,
  input wire logic RX_FRAME_START,
  input wire logic RX_BUF_OWNED,
  input wire logic BUS_TIMEOUT,
  input wire logic [23:0] DESC_PTR,
  // Status and configuration.
  output logic INTERRUPT_FLAG_N,
  output logic STOPPED,
  output logic [23:0] INIT_ADDR,
  output logic [15:0] BUS_CONFIG,
  output logic DESC_MISALIGNED
);
  // Current and next state.
  lan_csr_pkg::csr_t q, d;
  // Heartbeat missing pulse from the monitor.
  logic hb_missing;
  // A slave cycle that has not yet been answered.
  logic cyc_new;
  // Pointer port write in this cycle.
  logic ptr_wr;
  // Primary register write in this cycle.
  logic primary_control_status_wr;
  // Locked register write attempt in this cycle.
  logic cfg_wr;
  // Device running (not halted).
  logic run;
  // Overlength event in this cycle.
  logic overlength_transmit_flag_set;
  // Lost-frame event in this cycle.
  logic miss_set;

  // Builds the primary register image from the flag state.
  function automatic logic [15:0] primary_control_status_image(input lan_csr_pkg::csr_t s);
    logic [15:0] v;
    v = 16'h0000;
    v[lan_csr_pkg::B_ERR] = s.overlength_transmit_flag | s.heartbeat_missing_flag | s.miss | s.bus_timeout_flag;
    v[lan_csr_pkg::B_OVERLENGTH_TRANSMIT_FLAG] = s.overlength_transmit_flag;
    v[lan_csr_pkg::B_HEARTBEAT_MISSING_FLAG] = s.heartbeat_missing_flag;
    v[lan_csr_pkg::B_MISS] = s.miss;
    v[lan_csr_pkg::B_BUS_TIMEOUT_FLAG] = s.bus_timeout_flag;
    v[lan_csr_pkg::B_INTERRUPT_FLAG] = s.overlength_transmit_flag | s.miss | s.bus_timeout_flag;
    v[lan_csr_pkg::B_INTERRUPT_ENABLE_BIT] = s.interrupt_enable_bit;
    v[lan_csr_pkg::B_STOP] = s.stop;
    return v;
  endfunction : primary_control_status_image

  // True when the selected register may be touched now.
  function automatic logic reg_open(input logic [1:0] idx, input logic halted);
    return (idx == lan_csr_pkg::IDX_PRIMARY_CONTROL_STATUS) || halted;
  endfunction : reg_open

  // Heartbeat window monitor.
  heartbeat_monitor #(
    .WINDOW_CYC(lan_csr_pkg::HB_WINDOW_CYC)
  ) u_hb (
    .clk(CLOCK),
    .rst(RST),
    .enable(run),
    .tx_active(TX_ACTIVE),
    .collision(COLLISION),
    .missing(hb_missing)
  );

  // Decode of the host cycle and of the device events.
  always_comb begin
    run = !q.stop;
    cyc_new = !CS_N && !DAS_N && !q.busy;
    ptr_wr = cyc_new && !READ && ADR;
    primary_control_status_wr = cyc_new && !READ && !ADR && (q.ptr == lan_csr_pkg::IDX_PRIMARY_CONTROL_STATUS);
    cfg_wr = cyc_new && !READ && !ADR && (q.ptr != lan_csr_pkg::IDX_PRIMARY_CONTROL_STATUS);
    overlength_transmit_flag_set = run && TX_ACTIVE && TX_BYTE && (q.tx_cnt == lan_csr_pkg::OVERLENGTH_TRANSMIT_FLAG_LIMIT - 11'h001);
    // A drop without a buffer is only a lost frame; any overflow then has no
    // descriptor to carry status, so nothing else is raised for it.
    miss_set = run && RX_FRAME_START && !RX_BUF_OWNED;
  end

  // Next-state logic for the registers, flags and slave answer.
  always_comb begin
    logic [15:0] rd;
    logic stop_clr;
    rd = 16'h0000;
    stop_clr = 1'b0;
    d = q;
    // Sent-byte counter restarts with every frame and saturates.
    if (!TX_ACTIVE) begin
      d.tx_cnt = 11'h000;
    end else if (TX_BYTE && q.tx_cnt != 11'h7ff) begin
      d.tx_cnt = q.tx_cnt + 11'h001;
    end
    // Pointer port write keeps only the select field.
    if (ptr_wr) begin
      d.ptr = DAL_IN[1:0];
    end
    // Primary register write: halt, start and enable controls.
    if (primary_control_status_wr) begin
      if (DAL_IN[lan_csr_pkg::B_STOP]) begin
        d.stop = 1'b1;
        d.interrupt_enable_bit = 1'b0;
        stop_clr = 1'b1;
      end else begin
        if (DAL_IN[lan_csr_pkg::B_STRT] || DAL_IN[lan_csr_pkg::B_INIT]) begin
          d.stop = 1'b0;
        end
        d.interrupt_enable_bit = DAL_IN[lan_csr_pkg::B_INTERRUPT_ENABLE_BIT];
      end
    end
    // Flags: write one clears, halting clears, a new event wins over both.
    d.overlength_transmit_flag = overlength_transmit_flag_set |
      (q.overlength_transmit_flag & !(primary_control_status_wr & DAL_IN[lan_csr_pkg::B_OVERLENGTH_TRANSMIT_FLAG]) & !stop_clr);
    d.heartbeat_missing_flag = (run & hb_missing) |
      (q.heartbeat_missing_flag & !(primary_control_status_wr & DAL_IN[lan_csr_pkg::B_HEARTBEAT_MISSING_FLAG]) & !stop_clr);
    d.miss = miss_set |
      (q.miss & !(primary_control_status_wr & DAL_IN[lan_csr_pkg::B_MISS]) & !stop_clr);
    d.bus_timeout_flag = (run & BUS_TIMEOUT) |
      (q.bus_timeout_flag & !(primary_control_status_wr & DAL_IN[lan_csr_pkg::B_BUS_TIMEOUT_FLAG]) & !stop_clr);
    // Locked registers accept data only while halted.
    for (int i = 1; i < 4; i++) begin
      if (cfg_wr && reg_open(q.ptr, q.stop) && q.ptr == 2'(i)) begin
        d.cfg[i-1] = DAL_IN;
      end
    end
    // Initialization block address low register is word aligned.
    d.cfg[0][0] = 1'b0;
    // Read data: pointer port or the selected register.
    if (ADR) begin
      rd = {14'h0000, q.ptr};
    end else if (q.ptr == lan_csr_pkg::IDX_PRIMARY_CONTROL_STATUS) begin
      rd = primary_control_status_image(q);
    end else if (reg_open(q.ptr, q.stop)) begin
      rd = q.cfg[q.ptr - 2'h1];
    end
    // Slave answer: ready once per cycle, released when strobes drop.
    if (cyc_new) begin
      d.busy = 1'b1;
      d.ready_n = 1'b0;
      d.oe = READ;
      d.dout = READ ? rd : 16'h0000;
    end else if (CS_N || DAS_N) begin
      d.busy = 1'b0;
      d.ready_n = 1'b1;
      d.oe = 1'b0;
      d.dout = 16'h0000;
    end
    // Interrupt pin from the enable and the interrupt summary.
    d.interrupt_flag_n = !(q.interrupt_enable_bit & (q.overlength_transmit_flag | q.miss | q.bus_timeout_flag));
    // Descriptor entries must start on a quadword.
    d.misal = (DESC_PTR & lan_csr_pkg::QUAD_MASK) != 24'h000000;
  end

  // State register; reset halts and selects register zero.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      q <= '0;
      q.ptr <= lan_csr_pkg::IDX_PRIMARY_CONTROL_STATUS;
      q.stop <= lan_csr_pkg::PRIMARY_CONTROL_STATUS_RESET[lan_csr_pkg::B_STOP];
      q.ready_n <= 1'b1;
      q.interrupt_flag_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // All outputs come from state flip-flops.
  assign DAL_OUT = q.dout;
  assign DAL_OE = q.oe;
  assign READY_N = q.ready_n;
  assign INTERRUPT_FLAG_N = q.interrupt_flag_n;
  assign STOPPED = q.stop;
  assign INIT_ADDR = {q.cfg[1][7:0], q.cfg[0]};
  assign BUS_CONFIG = q.cfg[2];
  assign DESC_MISALIGNED = q.misal;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  // Pointer changes only through a pointer port write.
  property p_ptr_hold;
    !ptr_wr |=> $stable(q.ptr);
  endproperty
  a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved without write");

  // Pointer reads back as zero after reset.
  property p_ptr_reset;
    $past(RST) |-> q.ptr == 2'h0;
  endproperty
  a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not cleared");

  // Every new cycle is answered with ready on the next edge.
  property p_ready;
    cyc_new |=> !READY_N ##1 (READY_N || q.busy);
  endproperty
  a_ready: assert property (p_ready) else $error("slave cycle not answered");

  // Locked writes while running leave the registers untouched.
  property p_locked;
    (cfg_wr && !q.stop) |=> $stable(q.cfg);
  endproperty
  a_locked: assert property (p_locked) else $error("locked register written");

  // Pointer port reads show zero in the reserved bits.
  property p_ptr_read;
    (cyc_new && READ && ADR) |=> DAL_OE && DAL_OUT[15:2] == 14'h0000;
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("reserved pointer bits set");

  // The 1519th sent byte raises the overlength flag.
  property p_overlength_transmit_flag;
    (run && TX_ACTIVE && TX_BYTE && q.tx_cnt == 11'h5ee) |=> q.overlength_transmit_flag;
  endproperty
  a_overlength_transmit_flag: assert property (p_overlength_transmit_flag) else $error("overlength flag missed");

  // Writing one clears the overlength flag when no event coincides.
  property p_w1c;
    (primary_control_status_wr && DAL_IN[lan_csr_pkg::B_OVERLENGTH_TRANSMIT_FLAG] && !overlength_transmit_flag_set) |=> !q.overlength_transmit_flag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");

  // A drop without a buffer sets the lost-frame flag.
  property p_miss;
    (run && RX_FRAME_START && !RX_BUF_OWNED) |=> q.miss;
  endproperty
  a_miss: assert property (p_miss) else $error("lost frame not flagged");

  // Interrupt pin follows enable and summary one edge later.
  property p_interrupt_flag;
    INTERRUPT_FLAG_N == !($past(q.interrupt_enable_bit) && ($past(q.overlength_transmit_flag) || $past(q.miss) || $past(q.bus_timeout_flag)));
  endproperty
  a_interrupt_flag: assert property (p_interrupt_flag) else $error("interrupt pin wrong");

  // The heartbeat flag alone leaves the pin high.
  property p_heartbeat_missing_flag_quiet;
    (q.heartbeat_missing_flag && !q.overlength_transmit_flag && !q.miss && !q.bus_timeout_flag) |=> INTERRUPT_FLAG_N;
  endproperty
  a_heartbeat_missing_flag_quiet: assert property (p_heartbeat_missing_flag_quiet) else $error("heartbeat interrupted");

  // Error summary read back equals the flag OR.
  property p_err;
    (cyc_new && READ && !ADR && q.ptr == 2'h0) |=>
      DAL_OUT[15] == ($past(q.overlength_transmit_flag) | $past(q.heartbeat_missing_flag) | $past(q.miss) | $past(q.bus_timeout_flag));
  endproperty
  a_err: assert property (p_err) else $error("error summary wrong");

  // Main scenarios.
  c_ptr_write: cover property (ptr_wr ##[1:20] (cyc_new && !ADR));
  c_overlength_transmit_flag: cover property (overlength_transmit_flag_set);
  c_locked_write: cover property (cfg_wr && q.stop);
  c_heartbeat_missing_flag: cover property (hb_missing && run);
endmodule : lan_csr_access

// *** dv/host_bus_model.sv ***
// Purpose: Host processor model that issues slave read and write cycles.
// Assumes: Requests start on the falling edge and hold until ready is sampled.
// Notes: Released data lines show the inverse of the last value driven.
`timescale 1ns/1ps
module host_bus_model (
  // Clock.
  input wire logic clk,
  // Slave cycle pins driven by the host.
  output logic cs_n,
  output logic read,
  output logic das_n,
  output logic adr,
  output logic [15:0] dal_in,
  // Answer from the device.
  input wire logic ready_n,
  input wire logic [15:0] dal_out,
  input wire logic dal_oe
);
  // The bus idles with both strobes high.
  initial begin
    cs_n = 1'b1;
    das_n = 1'b1;
    read = 1'b0;
    adr = 1'b0;
    dal_in = 16'h0000;
  end

  // One slave cycle; ok stays low when no ready arrives in time.
  task automatic xfer(input logic a, input logic rd, input logic [15:0] wd,
                      output logic [15:0] rdata, output logic ok);
    int i;
    ok = 1'b0;
    rdata = 16'h0000;
    @(negedge clk);
    cs_n <= 1'b0;
    das_n <= 1'b0;
    read <= rd;
    adr <= a;
    dal_in <= wd;
    for (i = 0; i < 20 && !ok; i++) begin
      @(posedge clk);
      if (ready_n === 1'b0) begin
        ok = 1'b1;
        rdata = (rd && dal_oe === 1'b1) ? dal_out : 16'hxxxx;
      end
    end
    // Release after the answer edge, then leave a gap before the next cycle.
    @(negedge clk);
    cs_n <= 1'b1;
    das_n <= 1'b1;
    dal_in <= ~wd;
    repeat (2) @(negedge clk);
  endtask : xfer
endmodule : host_bus_model

// *** dv/testbench.sv ***
// Purpose: Self-checking bench for the register access and error flags.
// Assumes: Inputs change on the falling edge; seed fixed for repeatability.
// Notes: Undefined reads of locked registers are expected as zero.
`timescale 1ns/1ps
module testbench;
  logic clk, rst, cs_n, read, das_n, adr, oe, rdy_n, tx_act, tx_byte, coll;
  logic rx_start, rx_own, bus_to, interrupt_flag_n, stopped, misal;
  logic [15:0] din, dout, bcfg, seed;
  logic [23:0] desc, init_addr;
  logic [15:0] regv [1:3];
  int num_errors = 0;
  int n_tests = 0;
  int i;

  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  lan_csr_access DUT (.CLOCK(clk), .RST(rst), .CS_N(cs_n), .READ(read), .DAS_N(das_n),
    .ADR(adr), .DAL_IN(din), .DAL_OUT(dout), .DAL_OE(oe), .READY_N(rdy_n),
    .TX_ACTIVE(tx_act), .TX_BYTE(tx_byte), .COLLISION(coll), .RX_FRAME_START(rx_start),
    .RX_BUF_OWNED(rx_own), .BUS_TIMEOUT(bus_to), .DESC_PTR(desc), .INTERRUPT_FLAG_N(interrupt_flag_n),
    .STOPPED(stopped), .INIT_ADDR(init_addr), .BUS_CONFIG(bcfg), .DESC_MISALIGNED(misal));

  host_bus_model host (.clk(clk), .cs_n(cs_n), .read(read), .das_n(das_n), .adr(adr),
    .dal_in(din), .ready_n(rdy_n), .dal_out(dout), .dal_oe(oe));

  // Next value of the stimulus shift register.
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  // Expected primary register from the flags, enable and halt bit.
  function automatic logic [15:0] primary_control_status_exp(input logic bb, ce, ms, me, ie, st);
    return {bb | ce | ms | me, bb, ce, ms, me, 3'h0, bb | ms | me, ie, 3'h0, st, 2'h0};
  endfunction : primary_control_status_exp

  // Expected readback of a stored register; register one is word aligned.
  function automatic logic [15:0] reg_exp(input int idx, input logic [15:0] v);
    return (idx == 1) ? (v & 16'hfffe) : v;
  endfunction : reg_exp

  // Compare and count.
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Port write; every cycle must be answered.
  task automatic wr(input logic a, input logic [15:0] d);
    logic [15:0] r;
    logic ok;
    host.xfer(a, 1'b0, d, r, ok);
    check(ok, 1'b1);
  endtask : wr

  // Port read compared against an expectation.
  task automatic rd_chk(input logic a, input logic [15:0] exp);
    logic [15:0] r;
    logic ok;
    host.xfer(a, 1'b1, 16'h0000, r, ok);
    check(ok, 1'b1);
    check(r, exp);
  endtask : rd_chk

  // Select a register, then write it through the data window.
  task automatic csr_wr(input logic [1:0] idx, input logic [15:0] d);
    wr(1'b1, {14'h0000, idx});
    wr(1'b0, d);
  endtask : csr_wr

  // Select a register, then read it through the data window.
  task automatic csr_rd(input logic [1:0] idx, input logic [15:0] exp);
    wr(1'b1, {14'h0000, idx});
    rd_chk(1'b0, exp);
  endtask : csr_rd

  // One-cycle byte strobe.
  task automatic byte_pulse();
    @(negedge clk);
    tx_byte = 1'b1;
    @(negedge clk);
    tx_byte = 1'b0;
  endtask : byte_pulse

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog sized well above the expected run of about 4100 cycles.
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    rst = 1'b1;
    {tx_act, tx_byte, coll, rx_start, bus_to} = 5'h00;
    rx_own = 1'b1;
    desc = 24'h000000;
    seed = 16'h42fa;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check(stopped, 1'b1);
    rd_chk(1'b1, 16'h0000);
    rd_chk(1'b0, primary_control_status_exp(0, 0, 0, 0, 0, 1));
    // Fill the three halted-only registers, with junk in reserved pointer bits.
    for (i = 1; i < 4; i++) begin
      seed = lfsr(seed);
      regv[i] = seed;
      wr(1'b1, {seed[15:2], i[1:0]});
      rd_chk(1'b1, {14'h0000, i[1:0]});
      wr(1'b0, regv[i]);
      rd_chk(1'b0, reg_exp(i, regv[i]));
    end
    check(init_addr, {regv[2][7:0], regv[1] & 16'hfffe});
    check(bcfg, regv[3]);
    // Start with interrupts on; locked registers read zero and drop writes.
    csr_wr(2'h0, 16'h0042);
    check(stopped, 1'b0);
    csr_wr(2'h1, ~regv[1]);
    csr_rd(2'h1, 16'h0000);
    // A frame arriving with a buffer owned is not lost.
    @(negedge clk) rx_start = 1'b1;
    @(negedge clk) rx_start = 1'b0;
    csr_rd(2'h0, primary_control_status_exp(0, 0, 0, 0, 1, 0));
    rx_own = 1'b0;
    @(negedge clk) rx_start = 1'b1;
    @(negedge clk) rx_start = 1'b0;
    rd_chk(1'b0, primary_control_status_exp(0, 0, 1, 0, 1, 0));
    check(interrupt_flag_n, 1'b0);
    wr(1'b0, 16'h0040);
    rd_chk(1'b0, primary_control_status_exp(0, 0, 1, 0, 1, 0));
    wr(1'b0, 16'h1040);
    rd_chk(1'b0, primary_control_status_exp(0, 0, 0, 0, 1, 0));
    check(interrupt_flag_n, 1'b1);
    // Overlength frame with a heartbeat seen during it.
    tx_act = 1'b1;
    coll = 1'b1;
    for (i = 0; i < 1518; i++) byte_pulse();
    coll = 1'b0;
    csr_rd(2'h0, primary_control_status_exp(0, 0, 0, 0, 1, 0));
    byte_pulse();
    repeat (2) @(negedge clk);
    rd_chk(1'b0, primary_control_status_exp(1, 0, 0, 0, 1, 0));
    check(interrupt_flag_n, 1'b0);
    tx_act = 1'b0;
    wr(1'b0, 16'h0000);
    check(interrupt_flag_n, 1'b1);
    wr(1'b0, 16'h4040);
    // Let the trailing heartbeat window of the long frame close first.
    // A frame that starts inside that window would not be watched.
    repeat (410) @(negedge clk);
    // Short frame with no heartbeat at all.
    tx_act = 1'b1;
    repeat (10) @(negedge clk);
    tx_act = 1'b0;
    repeat (380) @(negedge clk);
    rd_chk(1'b0, primary_control_status_exp(0, 0, 0, 0, 1, 0));
    repeat (30) @(negedge clk);
    rd_chk(1'b0, primary_control_status_exp(0, 1, 0, 0, 1, 0));
    check(interrupt_flag_n, 1'b1);
    // Bus timeout, then halting clears every flag and the enable.
    @(negedge clk) bus_to = 1'b1;
    @(negedge clk) bus_to = 1'b0;
    rd_chk(1'b0, primary_control_status_exp(0, 1, 0, 1, 1, 0));
    wr(1'b0, 16'h0004);
    rd_chk(1'b0, primary_control_status_exp(0, 0, 0, 0, 0, 1));
    check(interrupt_flag_n, 1'b1);
    csr_rd(2'h1, reg_exp(1, regv[1]));
    // Descriptor alignment, aligned corner first.
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      desc = (i == 0) ? 24'h000010 : {seed[7:0], seed};
      repeat (2) @(negedge clk);
      check(misal, |desc[2:0]);
    end
    report_and_stop();
  end
endmodule : testbench
